// *** cpst_params.svh ***
// Field positions, reset values and bus constants for the processor status block
`ifndef CPST_PARAMS_SVH
`define CPST_PARAMS_SVH
`define CPST_ADDR_W          4
`define CPST_ADDR_STATUS     4'hc
`define CPST_ADDR_MODE_OUT   4'hd
`define CPST_CU_HI           31
`define CPST_CU_LO           28
`define CPST_FLIP_BIT        25
`define CPST_BOOT_BIT        22
`define CPST_TS_BIT          21
`define CPST_NMI_BIT         20
`define CPST_MASK_HI         15
`define CPST_MASK_LO         8
`define CPST_KU_OLD_BIT      5
`define CPST_IE_OLD_BIT      4
`define CPST_KU_PREV_BIT     3
`define CPST_IE_PREV_BIT     2
`define CPST_KU_CUR_BIT      1
`define CPST_IE_CUR_BIT      0
`define CPST_WRITE_MASK      32'hf032ff3f
`define CPST_RST_CU          4'h0
`define CPST_RST_MASK        8'h00
`define CPST_RST_STACK       6'h00
`define CPST_VEC_USER_TLB_REFILL_NORM   32'h80000000
`define CPST_VEC_USER_TLB_REFILL_BOOT   32'hbfc00100
`define CPST_VEC_GEN_NORM    32'h80000080
`define CPST_VEC_GEN_BOOT    32'hbfc00180
`endif

// *** cpst_pkg.sv ***
// Types shared by the processor status block
package cpst_pkg;
  typedef enum logic [1:0] {
    CPST_EV_NONE   = 2'b00,
    CPST_EV_EXC    = 2'b01,
    CPST_EV_RETURN = 2'b10
  } cpst_event_t;
  typedef struct packed {
    logic ku_old;
    logic ie_old;
    logic ku_prev;
    logic ie_prev;
    logic ku_cur;
    logic ie_cur;
  } cpst_stack_t;
endpackage : cpst_pkg

// *** cpst_stack_if.sv ***
// Interface between the status register and the mode stack unit
`timescale 1ns/1ps
`default_nettype none
interface cpst_stack_if;
  logic                      exc;
  logic                      ret;
  logic                      wr;
  cpst_pkg::cpst_stack_t     wdata;
  cpst_pkg::cpst_stack_t     stack;
  modport owner (output exc, output ret, output wr, output wdata, input stack);
  modport unit  (input exc, input ret, input wr, input wdata, output stack);
endinterface : cpst_stack_if
`default_nettype wire

// *** cpst_mode_stack.sv ***
// Three-level kernel/user and interrupt-enable stack
`timescale 1ns/1ps
`default_nettype none
`include "cpst_params.svh"
module cpst_mode_stack (
  input  wire logic  i_core_clk,
  input  wire logic  i_rst,
  cpst_stack_if.unit sif
);
  cpst_pkg::cpst_stack_t stack_reg;
  cpst_pkg::cpst_stack_t stack_next;

  // Exception beats return beats a software write; only one takes effect per cycle
  always_comb begin
    stack_next = stack_reg;
    if (sif.exc) begin
      stack_next.ku_old  = stack_reg.ku_prev;
      stack_next.ie_old  = stack_reg.ie_prev;
      stack_next.ku_prev = stack_reg.ku_cur;
      stack_next.ie_prev = stack_reg.ie_cur;
      stack_next.ku_cur  = 1'b0;
      stack_next.ie_cur  = 1'b0;
    end else if (sif.ret) begin
      stack_next.ku_cur  = stack_reg.ku_prev;
      stack_next.ie_cur  = stack_reg.ie_prev;
      stack_next.ku_prev = stack_reg.ku_old;
      stack_next.ie_prev = stack_reg.ie_old;
    end else if (sif.wr) begin
      stack_next = sif.wdata;
    end
  end

  // Reset clears the whole stack: kernel mode, interrupts off
  always_ff @(posedge i_core_clk) begin
    if (i_rst) stack_reg <= `CPST_RST_STACK;
    else       stack_reg <= stack_next;
  end

  assign sif.stack = stack_reg;

  AST_EXC_PUSH: assert property (@(posedge i_core_clk) disable iff (i_rst)
    sif.exc |=> stack_reg.ku_prev == $past(stack_reg.ku_cur) && !stack_reg.ku_cur
                && stack_reg.ie_old == $past(stack_reg.ie_prev) && !stack_reg.ie_cur)
    else $error("Exception push wrong");
  AST_RET_POP: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !sif.exc && sif.ret |=> stack_reg.ie_cur == $past(stack_reg.ie_prev)
                && stack_reg.ku_prev == $past(stack_reg.ku_old)
                && stack_reg.ku_old == $past(stack_reg.ku_old))
    else $error("Return pop wrong");
endmodule : cpst_mode_stack
`default_nettype wire

// *** cpst_status.sv ***
// Processor status register with coprocessor gates, endian, vectors and interrupts
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cpst_params.svh"
module cpst_status #(
  parameter int ADDR_W = `CPST_ADDR_W
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata,
  input  wire logic              i_exc_taken,
  input  wire logic              i_return_op,
  input  wire logic              i_cop_req,
  input  wire logic [1:0]        i_cop_num,
  input  wire logic              i_endian_pin,
  input  wire logic              i_nmi_n,
  input  wire logic [5:0]        i_hw_irq,
  input  wire logic [1:0]        i_sw_irq,
  output logic                   o_cop_unusable,
  output logic                   o_big_endian,
  output logic                   o_irq_req,
  output logic [31:0]            o_vec_user_tlb_refill,
  output logic [31:0]            o_vec_general
);
  cpst_stack_if sif ();

  logic [3:0]  cu_reg;
  logic [3:0]  cu_next;
  logic        flip_reg;
  logic        flip_next;
  logic        boot_reg;
  logic        boot_next;
  logic        nmi_reg;
  logic        nmi_next;
  logic        nmi_prev_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  mask_next;
  logic        reset_endian_reg;
  logic        in_reset_reg;
  logic        wr_status;
  logic        nmi_fall;
  logic [31:0] status_word;
  logic [31:0] rdata_next;
  logic        unus_next;
  logic        endian_next;
  logic        irq_next;
  logic [31:0] vutlb_next;
  logic [31:0] vgen_next;
  logic [31:0] rdata_reg;
  logic        unus_reg;
  logic        endian_reg;
  logic        irq_reg;
  logic [31:0] vutlb_reg;
  logic [31:0] vgen_reg;

  // Picks between normal and bootstrap vector; used for both vectors
  function automatic logic [31:0] pick_vec(input logic boot, input logic [31:0] norm,
                                           input logic [31:0] alt);
    pick_vec = boot ? alt : norm;
  endfunction : pick_vec

  assign wr_status = i_wr && (i_addr == `CPST_ADDR_STATUS);
  assign nmi_fall  = nmi_prev_reg && !i_nmi_n;

  // Stack unit gets the exception and return events plus software writes
  assign sif.exc   = i_exc_taken;
  assign sif.ret   = i_return_op;
  assign sif.wr    = wr_status;
  assign sif.wdata = cpst_pkg::cpst_stack_t'(i_wdata[5:0]);

  cpst_mode_stack u_stack (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .sif        (sif)
  );

  // Register word; reserved positions are tied to zero
  always_comb begin
    status_word = 32'h00000000;
    status_word[`CPST_CU_HI:`CPST_CU_LO]     = cu_reg;
    status_word[`CPST_FLIP_BIT]              = flip_reg;
    status_word[`CPST_BOOT_BIT]              = boot_reg;
    status_word[`CPST_TS_BIT]                = 1'b1;
    status_word[`CPST_NMI_BIT]               = nmi_reg;
    status_word[`CPST_MASK_HI:`CPST_MASK_LO] = mask_reg;
    status_word[5:0]                         = sif.stack;
  end

  // Software-written fields; only writable positions are taken
  always_comb begin
    cu_next   = cu_reg;
    flip_next = flip_reg;
    boot_next = boot_reg;
    mask_next = mask_reg;
    nmi_next  = nmi_reg;
    if (wr_status) begin
      cu_next   = i_wdata[`CPST_CU_HI:`CPST_CU_LO];
      flip_next = i_wdata[`CPST_FLIP_BIT];
      boot_next = i_wdata[`CPST_BOOT_BIT];
      mask_next = i_wdata[`CPST_MASK_HI:`CPST_MASK_LO];
      if (i_wdata[`CPST_NMI_BIT]) nmi_next = 1'b0;
    end
    // A new edge in the clearing cycle must not be lost
    if (nmi_fall) nmi_next = 1'b1;
  end

  // Field registers; reset turns on bootstrap vectors and drops the NMI flag
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cu_reg       <= `CPST_RST_CU;
      flip_reg     <= 1'b0;
      boot_reg     <= 1'b1;
      nmi_reg      <= 1'b0;
      mask_reg     <= `CPST_RST_MASK;
      nmi_prev_reg <= 1'b1;
      in_reset_reg <= 1'b1;
    end else begin
      cu_reg       <= cu_next;
      flip_reg     <= flip_next;
      boot_reg     <= boot_next;
      nmi_reg      <= nmi_next;
      mask_reg     <= mask_next;
      nmi_prev_reg <= i_nmi_n;
      in_reset_reg <= 1'b0;
    end
  end

  // Endian strap caught on the first clock after release, not under reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst)             reset_endian_reg <= 1'b0;
    else if (in_reset_reg) reset_endian_reg <= i_endian_pin;
  end

  // Output values computed from current state
  always_comb begin
    rdata_next = 32'h00000000;
    if (i_rd && i_addr == `CPST_ADDR_STATUS) rdata_next = status_word;
    else if (i_rd && i_addr == `CPST_ADDR_MODE_OUT)
      rdata_next = {31'h00000000, reset_endian_reg};
    // Coprocessor zero always usable in kernel mode
    unus_next = i_cop_req && !cu_reg[i_cop_num]
                && !(i_cop_num == 2'h0 && !sif.stack.ku_cur);
    // Flip only takes effect in user mode
    endian_next = reset_endian_reg ^ (flip_reg && sif.stack.ku_cur);
    irq_next = sif.stack.ie_cur
               && |({i_hw_irq, i_sw_irq} & mask_reg);
    vutlb_next = pick_vec(boot_reg, `CPST_VEC_USER_TLB_REFILL_NORM, `CPST_VEC_USER_TLB_REFILL_BOOT);
    vgen_next  = pick_vec(boot_reg, `CPST_VEC_GEN_NORM, `CPST_VEC_GEN_BOOT);
  end

  // Registered outputs
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_reg  <= 32'h00000000;
      unus_reg   <= 1'b0;
      endian_reg <= 1'b0;
      irq_reg    <= 1'b0;
      vutlb_reg  <= `CPST_VEC_USER_TLB_REFILL_BOOT;
      vgen_reg   <= `CPST_VEC_GEN_BOOT;
    end else begin
      rdata_reg  <= rdata_next;
      unus_reg   <= unus_next;
      endian_reg <= endian_next;
      irq_reg    <= irq_next;
      vutlb_reg  <= vutlb_next;
      vgen_reg   <= vgen_next;
    end
  end

  assign o_rdata        = rdata_reg;
  assign o_cop_unusable = unus_reg;
  assign o_big_endian   = endian_reg;
  assign o_irq_req      = irq_reg;
  assign o_vec_user_tlb_refill     = vutlb_reg;
  assign o_vec_general  = vgen_reg;

  AST_NMI_SET: assert property (@(posedge i_core_clk) disable iff (i_rst)
    nmi_fall |=> nmi_reg) else $error("NMI flag not set");
  AST_NMI_CLR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wr_status && i_wdata[`CPST_NMI_BIT] && !nmi_fall |=> !nmi_reg)
    else $error("NMI flag not cleared");
  AST_NMI_KEEP: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wr_status && !i_wdata[`CPST_NMI_BIT] |=> nmi_reg == $past(nmi_reg) || nmi_reg)
    else $error("NMI flag changed by zero write");
  AST_TS_ONE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_rd && i_addr == `CPST_ADDR_STATUS |=> o_rdata[`CPST_TS_BIT] && o_rdata[27:26] == 2'h0
    && o_rdata[24:23] == 2'h0 && o_rdata[19:16] == 4'h0 && o_rdata[7:6] == 2'h0)
    else $error("Fixed bits wrong on read");
  AST_IRQ_GATE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !sif.stack.ie_cur |=> !o_irq_req) else $error("Interrupt not masked");
  AST_IRQ_ON: assert property (@(posedge i_core_clk) disable iff (i_rst)
    sif.stack.ie_cur && (i_hw_irq[0] && mask_reg[2]) |=> o_irq_req)
    else $error("Enabled interrupt not requested");
  AST_KERNEL_CP0: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_cop_req && i_cop_num == 2'h0 && !sif.stack.ku_cur |=> !o_cop_unusable)
    else $error("Kernel denied coprocessor zero");
  AST_UNUSABLE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_cop_req && i_cop_num != 2'h0 && !cu_reg[i_cop_num] |=> o_cop_unusable)
    else $error("Unusable exception missing");
  AST_KERNEL_ENDIAN: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !sif.stack.ku_cur |=> o_big_endian == $past(reset_endian_reg))
    else $error("Kernel endian not strap");
  AST_VEC_BOOT: assert property (@(posedge i_core_clk) disable iff (i_rst)
    boot_reg |=> o_vec_user_tlb_refill == `CPST_VEC_USER_TLB_REFILL_BOOT && o_vec_general == `CPST_VEC_GEN_BOOT)
    else $error("Boot vectors wrong");
  AST_BOOT_RESET: assert property (@(posedge i_core_clk)
    $fell(i_rst) |-> boot_reg) else $error("Boot select not set by reset");
endmodule : cpst_status
`default_nettype wire

// *** cpst_pipe_model.sv ***
// Pipeline-side model: exception, return, coprocessor, interrupt and NMI events
`timescale 1ns/1ps
`default_nettype none
module cpst_pipe_model (
  input  wire logic       i_core_clk,
  output logic            o_exc_taken,
  output logic            o_return_op,
  output logic            o_cop_req,
  output logic [1:0]      o_cop_num,
  output logic            o_nmi_n,
  output logic [5:0]      o_hw_irq,
  output logic [1:0]      o_sw_irq
);
  // Idle pipeline: no events, NMI line released high, nothing pending
  initial begin
    o_exc_taken = 1'b0;
    o_return_op = 1'b0;
    o_cop_req   = 1'b0;
    o_cop_num   = 2'h0;
    o_nmi_n     = 1'b1;
    o_hw_irq    = 6'h00;
    o_sw_irq    = 2'h0;
  end
  // One-cycle exception pulse
  task automatic exc();
    @(posedge i_core_clk);
    o_exc_taken <= 1'b1;
    @(posedge i_core_clk);
    o_exc_taken <= 1'b0;
  endtask : exc
  // One-cycle return pulse
  task automatic ret();
    @(posedge i_core_clk);
    o_return_op <= 1'b1;
    @(posedge i_core_clk);
    o_return_op <= 1'b0;
  endtask : ret
  // NMI line low for three cycles; only the falling edge should count
  task automatic nmi_fall();
    @(posedge i_core_clk);
    o_nmi_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    o_nmi_n <= 1'b1;
  endtask : nmi_fall
  // Coprocessor request level; number is scrambled while idle so it is not trusted
  task automatic cop(input logic [1:0] num, input logic on);
    @(posedge i_core_clk);
    o_cop_req <= on;
    o_cop_num <= on ? num : ~num;
  endtask : cop
  // Pending interrupt lines
  task automatic irq(input logic [5:0] hw, input logic [1:0] sw);
    @(posedge i_core_clk);
    o_hw_irq <= hw;
    o_sw_irq <= sw;
  endtask : irq
endmodule : cpst_pipe_model
`default_nettype wire

// *** cpst_status_tb.sv ***
// Self-checking testbench for the processor status block
`timescale 1ns/1ps
`default_nettype none
`include "cpst_params.svh"
module cpst_status_tb;
  localparam logic [3:0] ST = `CPST_ADDR_STATUS;
  logic        i_core_clk = 1'b0;
  logic        i_rst      = 1'b1;
  logic [3:0]  i_addr     = 4'h0;
  logic [31:0] i_wdata    = 32'h0;
  logic        i_wr       = 1'b0;
  logic        i_rd       = 1'b0;
  logic [31:0] o_rdata, o_vec_user_tlb_refill, o_vec_general;
  logic        o_cop_unusable, o_big_endian, o_irq_req;
  logic        exc_taken, return_op, cop_req, nmi_n;
  logic [1:0]  cop_num, sw_irq;
  logic [5:0]  hw_irq;
  int          err_count = 0;
  int          n_checks  = 0;

  // 250 MHz core clock
  always #2 i_core_clk = ~i_core_clk;

  // Endian strap tied high so a reversal shows as a drop to zero
  cpst_status i_cpst_status (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_exc_taken(exc_taken), .i_return_op(return_op), .i_cop_req(cop_req),
    .i_cop_num(cop_num), .i_endian_pin(1'b1), .i_nmi_n(nmi_n), .i_hw_irq(hw_irq),
    .i_sw_irq(sw_irq), .o_cop_unusable(o_cop_unusable), .o_big_endian(o_big_endian),
    .o_irq_req(o_irq_req), .o_vec_user_tlb_refill(o_vec_user_tlb_refill), .o_vec_general(o_vec_general));

  cpst_pipe_model i_cpst_pipe_model (.i_core_clk(i_core_clk), .o_exc_taken(exc_taken),
    .o_return_op(return_op), .o_cop_req(cop_req), .o_cop_num(cop_num),
    .o_nmi_n(nmi_n), .o_hw_irq(hw_irq), .o_sw_irq(sw_irq));

  // Single comparison point; case inequality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : chk1
  // Register writes and reads, one-cycle strobes
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask : bus_wr
  // Read data stands only in the cycle after the strobe edge
  task automatic chk_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1;
    check(o_rdata, exp);
  endtask : chk_rd
  // Registered outputs take one cycle after their cause is sampled
  task automatic settle();
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask : settle
  task automatic do_reset();
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_core_clk);
  endtask : do_reset

  task automatic t_reset();
    chk_rd(ST, 32'h00600000);
    check(o_vec_user_tlb_refill, `CPST_VEC_USER_TLB_REFILL_BOOT);
    check(o_vec_general, `CPST_VEC_GEN_BOOT);
  endtask : t_reset
  // All ones, then zero: reserved bits, read-only bit, unmapped place
  task automatic t_fields();
    bus_wr(ST, 32'hffffffff);
    chk_rd(ST, 32'hf260ff3f);
    bus_wr(4'h3, 32'h0);
    chk_rd(ST, 32'hf260ff3f);
    chk_rd(4'h3, 32'h0);
    bus_wr(ST, 32'h0);
    chk_rd(ST, 32'h00200000);
    settle();
    check(o_vec_user_tlb_refill, `CPST_VEC_USER_TLB_REFILL_NORM);
    check(o_vec_general, `CPST_VEC_GEN_NORM);
  endtask : t_fields
  task automatic t_nmi();
    i_cpst_pipe_model.nmi_fall();
    settle();
    chk_rd(ST, 32'h00300000);
    bus_wr(ST, 32'h0);
    chk_rd(ST, 32'h00300000);
    bus_wr(ST, 32'h00100000);
    chk_rd(ST, 32'h00200000);
    i_cpst_pipe_model.nmi_fall();
    do_reset();
    chk_rd(ST, 32'h00600000);
  endtask : t_nmi
  // Push, pop, then two pushes with one idle cycle between them; the write also drops the boot bit
  task automatic t_stack();
    bus_wr(ST, 32'h0000000b);
    i_cpst_pipe_model.exc();
    chk_rd(ST, 32'h0020002c);
    i_cpst_pipe_model.ret();
    chk_rd(ST, 32'h0020002b);
    i_cpst_pipe_model.exc();
    i_cpst_pipe_model.exc();
    chk_rd(ST, 32'h00200030);
  endtask : t_stack
  task automatic t_irq();
    bus_wr(ST, 32'h00008001);
    i_cpst_pipe_model.irq(6'h20, 2'h0);
    settle();
    chk1(o_irq_req, 1'b1);
    i_cpst_pipe_model.irq(6'h1f, 2'h3);
    settle();
    chk1(o_irq_req, 1'b0);
    bus_wr(ST, 32'h0000ff00);
    settle();
    chk1(o_irq_req, 1'b0);
    bus_wr(ST, 32'h0000ff01);
    settle();
    chk1(o_irq_req, 1'b1);
    i_cpst_pipe_model.exc();
    settle();
    chk1(o_irq_req, 1'b0);
    i_cpst_pipe_model.irq(6'h00, 2'h0);
  endtask : t_irq
  task automatic t_cop();
    bus_wr(ST, 32'h0);
    i_cpst_pipe_model.cop(2'h0, 1'b1);
    settle();
    chk1(o_cop_unusable, 1'b0);
    i_cpst_pipe_model.cop(2'h1, 1'b1);
    settle();
    chk1(o_cop_unusable, 1'b1);
    bus_wr(ST, 32'h00000002);
    i_cpst_pipe_model.cop(2'h0, 1'b1);
    settle();
    chk1(o_cop_unusable, 1'b1);
    bus_wr(ST, 32'h80000002);
    i_cpst_pipe_model.cop(2'h3, 1'b1);
    settle();
    chk1(o_cop_unusable, 1'b0);
    i_cpst_pipe_model.cop(2'h0, 1'b0);
  endtask : t_cop
  task automatic t_endian();
    bus_wr(ST, 32'h02000000);
    settle();
    chk1(o_big_endian, 1'b1);
    bus_wr(ST, 32'h02000002);
    settle();
    chk1(o_big_endian, 1'b0);
    bus_wr(ST, 32'h00000002);
    settle();
    chk1(o_big_endian, 1'b1);
    chk_rd(`CPST_ADDR_MODE_OUT, 32'h00000001);
  endtask : t_endian

  // Verdict and end of run
  task automatic complete_run();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    err_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    t_reset();
    t_fields();
    t_nmi();
    t_stack();
    t_irq();
    t_cop();
    t_endian();
    complete_run();
  end
endmodule : cpst_status_tb
`default_nettype wire
